// [logic/cfdlsb_cfd.sv]
`timescale 1ns/1ps
`include "cfdlsb_map.svh"

module cfdlsb_cfd #(
   parameter int W = 10,
   parameter int CLIP_MAX = 16,
   parameter int DLY_DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] sample,
   input wire cfdlsb_pkg::cfdlsb_cfd_cfg_s cfg,
   output logic cross_pulse,
   output cfdlsb_pkg::cfdlsb_time_s time_out
);
   localparam int CW = W + 1;
   localparam int TW = $clog2(2 * DLY_DEPTH) + 1;
   localparam int DAW = $clog2(DLY_DEPTH);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (CLIP_MAX < 16 || W < 4 || W > 15 || (1 << DAW) != DLY_DEPTH) begin : g_chk
      $error("cfdlsb_cfd: unsupported W, CLIP_MAX or DLY_DEPTH");
   end

   // Sixteenths between two samples by restoring division, clamped to 15
   function automatic logic [3:0] substep(input logic [CW-1:0] num, input logic [CW-1:0] den);
      logic [CW+4:0] rem;
      logic [4:0] q;
      rem = {1'b0, num, 4'h0};
      q = '0;
      for (int i = 4; i >= 0; i--) begin
         if (den != '0 && rem >= ({5'h00, den} << i)) begin
            rem = rem - ({5'h00, den} << i);
            q[i] = 1'b1;
         end
      end
      substep = q[4] ? 4'hf : q[3:0];
   endfunction

   // ****************************************************************
   // Clipping: sample minus the sample clip_dly clocks earlier, one clock earlier for clip_dly 0
   // ****************************************************************
   logic [W-1:0] hist_q [CLIP_MAX];
   logic signed [CW-1:0] clip_q;
   wire [3:0] tap = (cfg.clip_dly == 4'h0) ? 4'h0 : cfg.clip_dly - 4'h1;
   wire signed [CW-1:0] clip_d = $signed({1'b0, sample}) - $signed({1'b0, hist_q[tap]});

   always_ff @(posedge clk) begin
      hist_q[0] <= sample;
      for (int i = 1; i < CLIP_MAX; i++) begin
         hist_q[i] <= hist_q[i-1];
      end
      clip_q <= clip_d;
   end

   // ****************************************************************
   // Memory delay line of clipped samples
   // ****************************************************************
   logic signed [CW-1:0] dl_mem [DLY_DEPTH];
   logic [DAW-1:0] dl_ptr_q;
   logic signed [CW-1:0] del_cur_q;
   logic signed [CW-1:0] del_prev_q;

   always_ff @(posedge clk) begin
      dl_mem[dl_ptr_q] <= clip_q;
      del_cur_q <= dl_mem[dl_ptr_q];
      del_prev_q <= del_cur_q;
   end

   // ****************************************************************
   // Amplitude, threshold and crossing search
   // ****************************************************************
   cfdlsb_pkg::cfdlsb_cfd_state_e state_q;
   logic [CW-2:0] max_q;
   logic [TW-1:0] tmo_q;
   logic [11:0] coarse_q;
   logic pulse_q;
   cfdlsb_pkg::cfdlsb_time_s time_q;

   wire signed [CW-1:0] hit_s = $signed({1'b0, cfg.hit_thr[CW-2:0]});
   wire hit = clip_q > hit_s;
   wire [CW+6:0] prod = {8'h00, max_q} * {{(CW-1){1'b0}}, cfg.fraction};
   wire signed [CW-1:0] thr = $signed({1'b0, prod[CW+6:`CFDLSB_FRAC_SHIFT]});
   wire found = (del_prev_q < thr) && (del_cur_q >= thr);
   wire [3:0] sub = substep(CW'(thr - del_prev_q), CW'(del_cur_q - del_prev_q));

   // Search starts only once the peak is over, so the delay line must be
   // longer than the clipped pulse or the crossing has already gone by
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= cfdlsb_pkg::CFDLSB_IDLE;
         max_q <= '0;
         tmo_q <= '0;
         coarse_q <= '0;
         dl_ptr_q <= '0;
         pulse_q <= 1'b0;
         time_q <= '0;
      end else begin
         coarse_q <= coarse_q + 12'h001;
         dl_ptr_q <= dl_ptr_q + 1'b1;
         pulse_q <= 1'b0;
         time_q.valid <= 1'b0;
         case (state_q)
            cfdlsb_pkg::CFDLSB_IDLE: begin
               if (hit) begin
                  state_q <= cfdlsb_pkg::CFDLSB_ARMED;
                  max_q <= clip_q[CW-2:0];
               end
            end
            cfdlsb_pkg::CFDLSB_ARMED: begin
               if (hit && clip_q[CW-2:0] > max_q) begin
                  max_q <= clip_q[CW-2:0];
               end
               if (!hit) begin
                  state_q <= cfdlsb_pkg::CFDLSB_SEARCH;
                  tmo_q <= '0;
               end
            end
            cfdlsb_pkg::CFDLSB_SEARCH: begin
               tmo_q <= tmo_q + 1'b1;
               if (found) begin
                  pulse_q <= 1'b1;
                  time_q.valid <= 1'b1;
                  time_q.word <= {coarse_q - 12'h001, sub};
                  state_q <= cfdlsb_pkg::CFDLSB_IDLE;
               end else if (tmo_q == TW'(2 * DLY_DEPTH - 1)) begin
                  state_q <= cfdlsb_pkg::CFDLSB_IDLE;
               end
            end
            default: state_q <= cfdlsb_pkg::CFDLSB_IDLE;
         endcase
      end
   end

   assign cross_pulse = pulse_q;
   assign time_out = time_q;
endmodule

// [logic/cfdlsb_latency.sv]
`timescale 1ns/1ps
`include "cfdlsb_map.svh"

module cfdlsb_latency #(
   parameter int W = 10,
   parameter int DEPTH = 512
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] delay,
   output logic [W-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (DEPTH > 512 || DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
      $error("cfdlsb_latency: DEPTH must be a power of two up to 512");
   end

   // ****************************************************************
   // Circular buffer
   // ****************************************************************
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [W-1:0] rd_q;
   wire [AW-1:0] rd_addr = wr_q - delay;

   // Pointer advances every cycle, the memory never stalls
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_q <= '0;
      end else begin
         wr_q <= wr_q + 1'b1;
      end
   end

   // Dual-port store; read-before-write so delay 0 yields the oldest slot
   always_ff @(posedge clk) begin
      mem[wr_q] <= wr_data;
      rd_q <= mem[rd_addr];
   end

   assign rd_data = rd_q;
endmodule

// [logic/cfdlsb_map.svh]
`ifndef CFDLSB_MAP_SVH
`define CFDLSB_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses, one aligned 32-bit word each)
// ****************************************************************
`define CFDLSB_REG_CTRL 8'h00
`define CFDLSB_REG_CLIP 8'h04
`define CFDLSB_REG_FRAC 8'h08
`define CFDLSB_REG_HIT 8'h0c
`define CFDLSB_REG_LAT 8'h10
`define CFDLSB_REG_SEG 8'h14
`define CFDLSB_REG_AFULL 8'h18
`define CFDLSB_REG_STATUS 8'h1c
`define CFDLSB_REG_TIME 8'h20
`define CFDLSB_REG_DROP 8'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define CFDLSB_CTRL_SRC_BIT 0
`define CFDLSB_ST_BUSY_BIT 12
`define CFDLSB_ST_AFULL_BIT 13
`define CFDLSB_FRAC_SHIFT 8
`define CFDLSB_SUBSTEP_BITS 4

// ****************************************************************
// Reset values
// ****************************************************************
`define CFDLSB_RST_CTRL 8'h00
`define CFDLSB_RST_CLIP 4'h3
`define CFDLSB_RST_FRAC 8'h80
`define CFDLSB_RST_HIT 16'h0010
`define CFDLSB_RST_LAT 9'h020
`define CFDLSB_RST_SEG 11'h010
`define CFDLSB_RST_AFULL 11'h300

`endif

// [logic/cfdlsb_pkg.sv]
package cfdlsb_pkg;

   // ****************************************************************
   // Discriminator states
   // ****************************************************************
   typedef enum logic [1:0] {
      CFDLSB_IDLE = 2'b00,
      CFDLSB_ARMED = 2'b01,
      CFDLSB_SEARCH = 2'b10
   } cfdlsb_cfd_state_e;

   // One segment FIFO entry: sample plus segment boundary flags
   typedef struct packed {
      logic first;
      logic last;
      logic [15:0] sample;
   } cfdlsb_seg_word_s;

   // Crossing time word: coarse sample count and sixteenths
   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } cfdlsb_time_s;

   // Discriminator settings
   typedef struct packed {
      logic [3:0] clip_dly;
      logic [7:0] fraction;
      logic [15:0] hit_thr;
   } cfdlsb_cfd_cfg_s;

endpackage

// [logic/cfdlsb_top.sv]
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "cfdlsb_map.svh"

module cfdlsb_top #(
   parameter int W = 10,
   parameter int LAT_DEPTH = 512,
   parameter int FIFO_DEPTH = 1024,
   parameter int DLY_DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [W-1:0] adc_sample,
   input wire logic [W-1:0] deconv_sample,
   input wire logic trig_accept,
   output logic cross_pulse,
   output logic almost_full,
   output logic time_valid,
   output logic [15:0] time_word,
   output logic seg_valid,
   input wire logic seg_ready,
   output cfdlsb_pkg::cfdlsb_seg_word_s seg_data
);
   localparam int FAW = $clog2(FIFO_DEPTH);
   localparam int PW = FAW + 1;
   localparam int LAW = $clog2(LAT_DEPTH);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (W > 15 || W < 4 || (1 << FAW) != FIFO_DEPTH || FIFO_DEPTH > 1024 || FIFO_DEPTH < 16) begin : g_chk
      $error("cfdlsb_top: unsupported W or FIFO_DEPTH");
   end

   // ****************************************************************
   // APB register file
   // ****************************************************************
   logic [7:0] ctrl_q;
   logic [3:0] clip_dly_q;
   logic [7:0] frac_q;
   logic [15:0] hit_q;
   logic [LAW-1:0] lat_q;
   logic [10:0] seg_len_q;
   logic [10:0] afull_lvl_q;
   logic [15:0] drop_q;
   logic [15:0] last_time_q;
   logic [31:0] prdata_q;

   // Address decode
   wire hit_ctrl = paddr == `CFDLSB_REG_CTRL;
   wire hit_clip = paddr == `CFDLSB_REG_CLIP;
   wire hit_frac = paddr == `CFDLSB_REG_FRAC;
   wire hit_hit = paddr == `CFDLSB_REG_HIT;
   wire hit_lat = paddr == `CFDLSB_REG_LAT;
   wire hit_seg = paddr == `CFDLSB_REG_SEG;
   wire hit_afull = paddr == `CFDLSB_REG_AFULL;
   wire hit_status = paddr == `CFDLSB_REG_STATUS;
   wire hit_time = paddr == `CFDLSB_REG_TIME;
   wire hit_drop = paddr == `CFDLSB_REG_DROP;
   wire addr_ok = hit_ctrl | hit_clip | hit_frac | hit_hit | hit_lat | hit_seg | hit_afull | hit_status | hit_time |
      hit_drop;
   // Bus phases: read data is taken at setup, a write lands only at the access edge
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wr_en = access & pwrite & addr_ok;

   // ****************************************************************
   // FIFO and gate state, declared early for status reads
   // ****************************************************************
   cfdlsb_pkg::cfdlsb_seg_word_s fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] fwr_q;
   logic [PW-1:0] frd_q;
   logic out_v_q;
   cfdlsb_pkg::cfdlsb_seg_word_s out_q;
   logic gate_q;
   logic [10:0] gate_cnt_q;
   logic afull_q;

   wire [PW-1:0] used = fwr_q - frd_q;
   wire [PW-1:0] free = PW'(FIFO_DEPTH) - used;
   wire fifo_full = used == PW'(FIFO_DEPTH);
   wire fifo_empty = used == '0;

   // Fill comparisons in a fixed 12-bit width, so every legal FIFO_DEPTH fits
   function automatic logic at_least(input logic [11:0] a, input logic [11:0] b);
      at_least = a >= b;
   endfunction

   // Status word: fill level, gate busy, almost full
   logic [31:0] status_w;
   always_comb begin
      status_w = '0;
      status_w[PW-1:0] = used;
      status_w[`CFDLSB_ST_BUSY_BIT] = gate_q;
      status_w[`CFDLSB_ST_AFULL_BIT] = afull_q;
   end

   // Read mux; unmapped addresses read zero
   wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_q} :
      hit_clip ? {28'h0000000, clip_dly_q} :
      hit_frac ? {24'h000000, frac_q} :
      hit_hit ? {16'h0000, hit_q} :
      hit_lat ? 32'(lat_q) :
      hit_seg ? {21'h000000, seg_len_q} :
      hit_afull ? {21'h000000, afull_lvl_q} :
      hit_status ? status_w :
      hit_time ? {16'h0000, last_time_q} :
      hit_drop ? {16'h0000, drop_q} : 32'h00000000;

   // Settings registers; read data captured in the setup cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_q <= `CFDLSB_RST_CTRL;
         clip_dly_q <= `CFDLSB_RST_CLIP;
         frac_q <= `CFDLSB_RST_FRAC;
         hit_q <= `CFDLSB_RST_HIT;
         lat_q <= LAW'(`CFDLSB_RST_LAT);
         seg_len_q <= `CFDLSB_RST_SEG;
         afull_lvl_q <= `CFDLSB_RST_AFULL;
         prdata_q <= '0;
      end else begin
         if (setup) begin
            prdata_q <= rd_mux;
         end
         if (wr_en && hit_ctrl) ctrl_q <= pwdata[7:0];
         if (wr_en && hit_clip) clip_dly_q <= pwdata[3:0];
         if (wr_en && hit_frac) frac_q <= pwdata[7:0];
         if (wr_en && hit_hit) hit_q <= pwdata[15:0];
         if (wr_en && hit_lat) lat_q <= pwdata[LAW-1:0];
         if (wr_en && hit_seg) seg_len_q <= pwdata[10:0];
         if (wr_en && hit_afull) afull_lvl_q <= pwdata[10:0];
      end
   end

   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   // Misaligned or unmapped offsets are refused and their writes ignored
   assign pslverr = access & ~addr_ok;
   assign prdata = prdata_q;

   // ****************************************************************
   // Discriminator
   // ****************************************************************
   cfdlsb_pkg::cfdlsb_cfd_cfg_s cfd_cfg;
   cfdlsb_pkg::cfdlsb_time_s cfd_time;
   logic cfd_pulse;

   assign cfd_cfg.clip_dly = clip_dly_q;
   assign cfd_cfg.fraction = frac_q;
   assign cfd_cfg.hit_thr = hit_q;

   cfdlsb_cfd #(
      .W(W),
      .CLIP_MAX(16),
      .DLY_DEPTH(DLY_DEPTH)
   ) u_cfd (
      .clk(clk),
      .reset_n(reset_n),
      .sample(adc_sample),
      .cfg(cfd_cfg),
      .cross_pulse(cfd_pulse),
      .time_out(cfd_time)
   );

   // Crossing pulse goes straight to the trigger side
   assign cross_pulse = cfd_pulse;

   // Time word held for the event path and for software
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         last_time_q <= '0;
      end else if (cfd_time.valid) begin
         last_time_q <= cfd_time.word;
      end
   end

   assign time_valid = cfd_time.valid;
   assign time_word = last_time_q;

   // ****************************************************************
   // Latency buffer
   // ****************************************************************
   wire [W-1:0] lat_in = ctrl_q[`CFDLSB_CTRL_SRC_BIT] ? deconv_sample : adc_sample;
   logic [W-1:0] lat_out;

   cfdlsb_latency #(
      .W(W),
      .DEPTH(LAT_DEPTH)
   ) u_lat (
      .clk(clk),
      .reset_n(reset_n),
      .wr_data(lat_in),
      .delay(lat_q),
      .rd_data(lat_out)
   );

   // ****************************************************************
   // Transfer gate
   // ****************************************************************
   // Space for the whole segment is reserved at start, so a started gate
   // never truncates; a trigger that finds no room is counted and dropped
   wire room = at_least(12'(free), 12'(seg_len_q));
   wire start = trig_accept & ~gate_q & (seg_len_q != 11'h000) & room;
   wire refuse = trig_accept & ~start;
   wire push = gate_q & ~fifo_full;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gate_q <= 1'b0;
         gate_cnt_q <= '0;
      end else if (start) begin
         gate_q <= 1'b1;
         gate_cnt_q <= seg_len_q;
      end else if (push) begin
         gate_cnt_q <= gate_cnt_q - 11'h001;
         if (gate_cnt_q == 11'h001) begin
            gate_q <= 1'b0;
         end
      end
   end

   // Dropped-trigger counter; a write clears it but a drop in the same cycle still counts
   wire drop_clr = wr_en & hit_drop;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         drop_q <= '0;
      end else if (drop_clr) begin
         drop_q <= {15'h0000, refuse};
      end else if (refuse && drop_q != 16'hffff) begin
         drop_q <= drop_q + 16'h0001;
      end
   end

   // ****************************************************************
   // Segment FIFO
   // ****************************************************************
   cfdlsb_pkg::cfdlsb_seg_word_s push_word;
   always_comb begin
      push_word.first = gate_cnt_q == seg_len_q;
      push_word.last = gate_cnt_q == 11'h001;
      push_word.sample = 16'(lat_out);
   end

   // Output stage refills whenever empty or being taken
   wire pop = ~fifo_empty & (~out_v_q | seg_ready);

   // Storage has no reset; only pointers, the output flag and the almost-full flag need one
   always_ff @(posedge clk) begin
      if (push) begin
         fifo_mem[fwr_q[FAW-1:0]] <= push_word;
      end
      if (pop) begin
         out_q <= fifo_mem[frd_q[FAW-1:0]];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fwr_q <= '0;
         frd_q <= '0;
         out_v_q <= 1'b0;
         afull_q <= 1'b0;
      end else begin
         if (push) fwr_q <= fwr_q + 1'b1;
         if (pop) frd_q <= frd_q + 1'b1;
         if (pop) begin
            out_v_q <= 1'b1;
         end else if (seg_ready) begin
            out_v_q <= 1'b0;
         end
         afull_q <= at_least(12'(used), 12'(afull_lvl_q));
      end
   end

   assign seg_valid = out_v_q;
   assign seg_data = out_q;
   assign almost_full = afull_q;
endmodule

// [tb/cfdlsb_chk.sv]
`timescale 1ns/1ps
module cfdlsb_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic trig_accept,
   input wire logic cross_pulse,
   input wire logic almost_full,
   input wire logic time_valid,
   input wire logic [15:0] time_word,
   input wire logic seg_valid,
   input wire logic seg_ready,
   input wire cfdlsb_pkg::cfdlsb_seg_word_s seg_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ****************************************************************
   // Steps of the reader handshake and of a trigger
   // ****************************************************************
   sequence s_wait;
      seg_valid && !seg_ready;
   endsequence
   sequence s_trig_room;
      trig_accept && !seg_valid && !almost_full;
   endsequence
   chk_pulse_single: assert property (cross_pulse |=> !cross_pulse)
      else $error("crossing pulse longer than one cycle");
   chk_time_pair: assert property (cross_pulse |-> time_valid)
      else $error("crossing pulse without time word");
   chk_time_hold: assert property ($changed(time_word) |-> $past(time_valid))
      else $error("time word changed without a crossing");
   chk_seg_hold: assert property (s_wait |=> seg_valid && $stable(seg_data))
      else $error("segment entry lost before it was taken");
   chk_trig_push: assert property (s_trig_room |-> ##[1:6] seg_valid)
      else $error("accepted trigger produced no segment");
   chk_apb_ready: assert property (psel && penable |-> pready)
      else $error("bus access not completed");
   chk_unmapped_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
      else $error("unmapped access not refused");
   chk_mapped_ok: assert property (psel && penable && paddr <= 8'h24 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   chk_reset_quiet: assert property ($rose(reset_n) |-> !seg_valid && !cross_pulse && !almost_full && !time_valid)
      else $error("outputs active after reset");
endmodule

bind cfdlsb_top cfdlsb_chk cfdlsb_chk_inst (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .trig_accept(trig_accept),
   .cross_pulse(cross_pulse), .almost_full(almost_full), .time_valid(time_valid), .time_word(time_word),
   .seg_valid(seg_valid), .seg_ready(seg_ready), .seg_data(seg_data));

// [tb/cfdlsb_far_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Far side: sample source and list reader
// ****************************************************************
module cfdlsb_far_model (
   input wire logic clk,
   input wire logic ramp,
   input wire logic fire,
   input wire logic [9:0] amp,
   input wire logic stall,
   output logic [9:0] adc_sample,
   output logic [9:0] deconv_sample,
   output logic seg_ready
);
   logic [9:0] cnt_q = 10'h000;
   logic [9:0] lvl_q = 10'h000;
   logic [1:0] ph_q = 2'h0;
   // Steps only add, so the clipped signal never swings negative
   always @(posedge clk) begin
      cnt_q <= cnt_q + 10'h001;
      ph_q <= ph_q + 2'h1;
      if (fire) begin
         lvl_q <= lvl_q + amp;
      end
   end
   // Ramp makes every delayed sample tell its own age
   assign adc_sample = ramp ? cnt_q : lvl_q;
   assign deconv_sample = ~adc_sample; // Inverted so the source is visible
   // Reader drains at its own pace and stalls every fourth cycle
   assign seg_ready = !stall && (ph_q != 2'h3);
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [9:0] adc_sample;
   logic [9:0] deconv_sample;
   logic trig_accept = 1'b0;
   logic cross_pulse;
   logic almost_full;
   logic time_valid;
   logic [15:0] time_word;
   logic seg_valid;
   logic seg_ready;
   cfdlsb_pkg::cfdlsb_seg_word_s seg_data;
   logic ramp = 1'b0;
   logic fire = 1'b0;
   logic [9:0] amp = 10'h000;
   logic stall = 1'b0;
   int n_errors = 0;
   int comparisons = 0;
   int n_cross = 0;
   // ****************************************************************
   // Clock, design and far side
   // ****************************************************************
   always #5 clk = ~clk;
   cfdlsb_top cfdlsb_top_inst (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adc_sample(adc_sample), .deconv_sample(deconv_sample), .trig_accept(trig_accept),
      .cross_pulse(cross_pulse), .almost_full(almost_full), .time_valid(time_valid), .time_word(time_word),
      .seg_valid(seg_valid), .seg_ready(seg_ready), .seg_data(seg_data));
   cfdlsb_far_model cfdlsb_far_model_inst (.clk(clk), .ramp(ramp), .fire(fire), .amp(amp), .stall(stall),
      .adc_sample(adc_sample), .deconv_sample(deconv_sample), .seg_ready(seg_ready));
   // Crossing pulses are tallied so a missing or extra one shows up
   always @(posedge clk) begin
      if (cross_pulse === 1'b1) n_cross <= n_cross + 1;
   end
   task automatic stop_test;
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus cycle: request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask
   // Trigger held cyc cycles; v is the sample in the accept cycle
   task automatic trig(input int cyc, output logic [9:0] v);
      @(posedge clk);
      trig_accept <= 1'b1;
      #1 v = adc_sample;
      repeat (cyc) @(posedge clk);
      trig_accept <= 1'b0;
   endtask
   task automatic pop(output cfdlsb_pkg::cfdlsb_seg_word_s s);
      int n = 0;
      @(posedge clk);
      while (!(seg_valid === 1'b1 && seg_ready === 1'b1) && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (n >= 100) n_errors++;
      s = seg_data;
   endtask
   // Watchdog: the tests need under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      stop_test();
   end
   initial begin
      cfdlsb_pkg::cfdlsb_seg_word_s s;
      logic [9:0] v;
      logic [9:0] e10;
      logic [31:0] r;
      logic e;
      static logic [31:0] rst [6] = '{32'h3, 32'h80, 32'h10, 32'h20, 32'h10, 32'h300};
      int nc;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++) rdc(8'h04 + 8'(4 * i), rst[i]);
      apb(1'b0, 8'h28, 32'h0, r, e);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      // Steps: two at half fraction and quarter fraction, one below the hit level
      for (int k = 0; k < 3; k++) begin
         wr(8'h08, (k == 1) ? 32'h40 : 32'h80);
         nc = n_cross;
         @(posedge clk);
         amp <= (k == 2) ? 10'h008 : 10'h040;
         fire <= 1'b1;
         @(posedge clk);
         fire <= 1'b0;
         repeat (200) @(posedge clk);
         chk(32'(n_cross - nc), (k == 2) ? 32'h0 : 32'h1);
         if (k < 2) chk(32'(time_word[3:0]), (k == 1) ? 32'h4 : 32'h8);
      end
      // Delayed segments from raw and from deconvolved input
      ramp <= 1'b1;
      wr(8'h14, 32'h2);
      for (int k = 0; k < 2; k++) begin
         wr(8'h00, 32'(k));
         wr(8'h10, k ? 32'h9 : 32'h4);
         repeat (20) @(posedge clk);
         trig(2, v);
         for (int j = 0; j < 2; j++) begin
            pop(s);
            e10 = v - (k ? 10'h009 : 10'h004) + 10'(j);
            if (k) e10 = ~e10;
            chk(32'(s), {14'h0, j == 0, j == 1, 6'h00, e10});
         end
      end
      rdc(8'h24, 32'h2);
      // Reader stalled: almost full must rise, then fall once drained
      wr(8'h24, 32'h0);
      wr(8'h18, 32'h3);
      wr(8'h14, 32'h4);
      stall <= 1'b1;
      trig(1, v);
      repeat (10) @(posedge clk);
      chk(32'(almost_full), 32'h1);
      stall <= 1'b0;
      for (int j = 0; j < 4; j++) begin
         pop(s);
         chk(32'({s.first, s.last}), {30'h0, j == 0, j == 3});
      end
      repeat (5) @(posedge clk);
      chk(32'(almost_full), 32'h0);
      stop_test();
   end
endmodule
